// file: rtl/gtm_pkg.sv
// Package of offsets, field layouts and reset values for the gated timer
package gtm_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] OFS_COUNT_LOW  = 4'h0; // Count low byte
    localparam logic [3:0] OFS_COUNT_HIGH = 4'h1; // Count high byte
    localparam logic [3:0] OFS_CONTROL    = 4'h2; // Timer control
    localparam logic [3:0] OFS_SELECT     = 4'h3; // Clock and gate select
    localparam logic [3:0] OFS_FLAGS      = 4'h4; // Peripheral flag register
    localparam logic [3:0] OFS_ENABLES    = 4'h5; // Interrupt enables
    localparam logic [3:0] OFS_CMP_LOW    = 4'h6; // Compare low byte
    localparam logic [3:0] OFS_CMP_HIGH   = 4'h7; // Compare high byte
    localparam logic [3:0] OFS_CCP_MODE   = 4'h8; // Capture/compare mode
    localparam logic [3:0] OFS_PINS       = 4'h9; // Shared pin view
    // ---------------------------------------------------------------
    // Gate sources
    // ---------------------------------------------------------------
    localparam logic [1:0] GATE_PIN     = 2'h0; // Gate pin
    localparam logic [1:0] GATE_ALT_PIN = 2'h1; // Alternate gate pin
    localparam logic [1:0] GATE_CMP     = 2'h2; // Comparator output
    // ---------------------------------------------------------------
    // Counts and reset values
    // ---------------------------------------------------------------
    localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;    // Oscillator divided by four
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF; // Last count before rollover
    localparam logic [15:0] COUNT_RESET    = 16'h0000; // Count after reset
    localparam logic [7:0]  BYTE_RESET     = 8'h00;    // Generic byte reset
    // Timer control layout
    typedef struct packed {
        logic       gate_invert;
        logic       gate_enable;
        logic [1:0] prescale_select;
        logic       timer_oscillator_enable;
        logic       sync_disable;
        logic       clock_source_select;
        logic       timer_on;
    } gtm_ctrl_t;
    // Clock and gate select layout
    typedef struct packed {
        logic [4:0] unused;
        logic [1:0] gate_source;
        logic       alternate_clock_select;
    } gtm_sel_t;
    // Capture/compare mode layout
    typedef struct packed {
        logic [4:0] unused;
        logic       special_trigger;
        logic       compare_enable;
        logic       capture_enable;
    } gtm_ccp_t;
    // Register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } gtm_bus_t;
endpackage : gtm_pkg

// file: rtl/gtm_timer.sv
// Gated sixteen bit timer with prescaler, gate, capture and compare
//
// Summary of operation
// - Sixteen bit counter, byte writes replace bytes
// - Source selects instruction, oscillator or pin
// - Prescaler divides by one, two, four, eight
// - Prescaler hidden, cleared by count writes
// - Pin rising edges counted, sync or async
// - Falling edge needed before first counted rise
// - Oscillator enable starts crystal, runs in sleep
// - Oscillator forces pin directions, fixed readback
// - Sync disable bypasses the synchroniser
// - Count byte reads always return valid byte
// - Gate source selectable, active when enabled
// - Gate invert reverses gate polarity
// - Invert one counts high, zero counts low
// - Rollover to zero sets overflow flag
// - Interrupt needs all three enables set
// - Sleep counting only async; overflow wakes
// - Capture event copies count to pair
// - Compare match raises event
// - Special trigger clears count, no flag
// - Count write beats special trigger clear
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module gtm_timer (
    // Clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       ARST_N,
    // Register port
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output var  logic [7:0] RDATA,
    // Count and gate inputs
    input  wire logic       EXT_COUNT_IN,
    input  wire logic       GATE_PIN_IN,
    input  wire logic       ALT_GATE_PIN_IN,
    input  wire logic       COMPARATOR_OUTPUT,
    input  wire logic       CAPTURE_EVENT,
    input  wire logic       SLEEP,
    // Shared oscillator pins
    input  wire logic       PIN5_IN,
    input  wire logic       PIN4_IN,
    output var  logic       PIN5_DIRECTION,
    output var  logic       PIN4_DIRECTION,
    output var  logic       OSC_ENABLE,
    // Events
    output var  logic       IRQ,
    output var  logic       WAKE,
    output var  logic       COMPARE_EVENT
);
    import gtm_pkg::*;

    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    logic       rst_meta;  // First reset stage
    logic       rst_n;     // Released reset

    // Two flops release the asynchronous reset
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ---------------------------------------------------------------
    // Registers and bus decode
    // ---------------------------------------------------------------
    gtm_bus_t   bus;           // Bundled request
    gtm_ctrl_t  ctrl;          // Timer control
    gtm_sel_t   sel;           // Clock and gate select
    gtm_ccp_t   ccp;           // Capture/compare mode
    logic [15:0] count;        // Timer count
    logic [15:0] cmp;          // Compare/capture pair
    logic        flag;         // Overflow flag
    logic [2:0]  ien;          // Gie, peripheral_interrupt_enable, overflow enable
    logic        dir5;         // Pin5 direction latch
    logic        dir4;         // Pin4 direction latch
    logic        on_d;         // Timer on, previous cycle

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    wire wr_low  = bus.wr && bus.addr == OFS_COUNT_LOW;   // Low byte write
    wire wr_high = bus.wr && bus.addr == OFS_COUNT_HIGH;  // High byte write
    wire wr_cnt  = wr_low || wr_high;                     // Any count write
    wire wr_flag = bus.wr && bus.addr == OFS_FLAGS;       // Flag write

    // Control registers written by software
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
            sel  <= '0;
            ccp  <= '0;
            ien  <= 3'h0;
            dir5 <= 1'b1;
            dir4 <= 1'b1;
        end else if (bus.wr) begin
            case (bus.addr)
                OFS_CONTROL:  ctrl <= bus.wdata;
                OFS_SELECT:   sel  <= {5'h00, bus.wdata[2:0]};
                OFS_CCP_MODE: ccp  <= {5'h00, bus.wdata[2:0]};
                OFS_ENABLES:  ien  <= bus.wdata[2:0];
                OFS_PINS: begin
                    dir5 <= bus.wdata[3];
                    dir4 <= bus.wdata[2];
                end
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // External input edges
    // ---------------------------------------------------------------
    logic       s_meta;   // Synchroniser first stage
    logic       s_sync;   // Synchroniser second stage
    logic       s_last;   // Previous synchronised level
    logic       a_now;    // Unsynchronised path sample
    logic       a_last;   // Previous unsynchronised sample

    // Two stage synchroniser plus direct path
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_meta <= 1'b0;
            s_sync <= 1'b0;
            s_last <= 1'b0;
            a_now  <= 1'b0;
            a_last <= 1'b0;
        end else begin
            s_meta <= EXT_COUNT_IN;
            s_sync <= s_meta;
            s_last <= s_sync;
            // Direct path takes one flop, no second stage
            a_now  <= EXT_COUNT_IN;
            a_last <= a_now;
        end
    end

    // Mode picks the synchronised or the direct path
    wire in_lvl  = ctrl.sync_disable ? a_now : s_sync;
    wire in_prev = ctrl.sync_disable ? a_last : s_last;
    wire in_rise = in_lvl && !in_prev;
    wire in_fall = !in_lvl && in_prev;

    // ---------------------------------------------------------------
    // Falling edge arming
    // ---------------------------------------------------------------
    logic       armed;     // Falling edge seen
    logic       ever_on;   // Enabled since reset
    logic       lvl_off;   // Input level when disabled

    wire on_rise = ctrl.timer_on && !on_d;                      // Enable edge
    // A write disarms at once; a re-enable disarms on the first
    // enable or when the input fell while the timer was off
    wire need_fall = wr_cnt || (on_rise && (!ever_on || (lvl_off && !in_lvl)));

    // Arm on falling edge, disarm on the three conditions
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            armed   <= 1'b0;
            ever_on <= 1'b0;
            lvl_off <= 1'b0;
            on_d    <= 1'b0;
        end else begin
            on_d <= ctrl.timer_on;
            if (on_rise)
                ever_on <= 1'b1;
            if (on_d && !ctrl.timer_on)
                lvl_off <= in_lvl;
            if (need_fall)
                armed <= 1'b0;
            else if (in_fall)
                armed <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Clock select, gate and prescaler
    // ---------------------------------------------------------------
    logic [1:0] idiv;      // Instruction clock divider
    logic [2:0] pre;       // Prescale counter, not visible

    // Instruction clock ticks once in four cycles
    wire instr_tick = idiv == INSTR_DIV_LAST;
    // Full oscillator clock ticks on every cycle
    wire src_tick = ctrl.clock_source_select ? (in_rise && armed)
                  : (sel.alternate_clock_select ? 1'b1 : instr_tick);

    // Gate selection and polarity
    wire gate_raw = sel.gate_source == GATE_CMP ? COMPARATOR_OUTPUT
                  : sel.gate_source == GATE_ALT_PIN ? ALT_GATE_PIN_IN
                  : GATE_PIN_IN;
    wire gate_act = ctrl.gate_invert ? gate_raw : !gate_raw;
    // Only the asynchronous pin path counts in sleep
    wire sleep_ok = !SLEEP || (ctrl.clock_source_select && ctrl.sync_disable);
    wire run = ctrl.timer_on && (!ctrl.gate_enable || gate_act) && sleep_ok;

    wire [2:0] pre_last = 3'((4'h1 << ctrl.prescale_select) - 4'h1);
    // Reaching or passing the last value ends a period, so a lower
    // ratio set mid-period does not wait for the counter to wrap
    wire pre_tick = run && src_tick && pre >= pre_last;

    // Instruction divider and prescaler
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            idiv <= 2'h0;
            pre  <= 3'h0;
        end else begin
            idiv <= idiv + 2'h1;
            if (wr_cnt || pre_tick)
                pre <= 3'h0;
            else if (run && src_tick)
                pre <= pre + 3'h1;
        end
    end

    // ---------------------------------------------------------------
    // Counter, capture and compare
    // ---------------------------------------------------------------
    // Match is a level, so a stopped count on a zero pair keeps clearing
    wire match = ccp.compare_enable && cmp == count;
    wire special = match && ccp.special_trigger;
    wire overflow = pre_tick && count == COUNT_MAX;
    logic [15:0] next_count;

    // Write beats special trigger, which beats increment
    always_comb begin
        next_count = count;
        if (wr_low)
            next_count = {count[15:8], bus.wdata};
        else if (wr_high)
            next_count = {bus.wdata, count[7:0]};
        else if (special)
            next_count = COUNT_RESET;
        else if (pre_tick)
            next_count = count + 16'h0001;
    end

    // Count, compare pair and flag
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            count <= COUNT_RESET;
            cmp   <= COUNT_RESET;
            flag  <= 1'b0;
        end else begin
            count <= next_count;
            if (ccp.capture_enable && CAPTURE_EVENT)
                cmp <= count;
            else if (bus.wr && bus.addr == OFS_CMP_LOW)
                cmp[7:0] <= bus.wdata;
            else if (bus.wr && bus.addr == OFS_CMP_HIGH)
                cmp[15:8] <= bus.wdata;
            // A rollover set wins over a software clear
            if (overflow && !wr_cnt && !special)
                flag <= 1'b1;
            else if (wr_flag)
                flag <= bus.wdata[0];
        end
    end

    // ---------------------------------------------------------------
    // Read path and outputs
    // ---------------------------------------------------------------
    wire osc = ctrl.timer_oscillator_enable;
    // Oscillator on: pins read as inputs, port bits as zero
    wire [7:0] pin_view = osc ? 8'h0C
                        : {4'h0, dir5, dir4, PIN5_IN, PIN4_IN};
    logic [7:0] rd_mux;

    // Read selection from the current state
    always_comb begin
        case (bus.addr)
            OFS_COUNT_LOW:  rd_mux = count[7:0];
            OFS_COUNT_HIGH: rd_mux = count[15:8];
            OFS_CONTROL:    rd_mux = ctrl;
            OFS_SELECT:     rd_mux = sel;
            OFS_FLAGS:      rd_mux = {7'h00, flag};
            OFS_ENABLES:    rd_mux = {5'h00, ien};
            OFS_CMP_LOW:    rd_mux = cmp[7:0];
            OFS_CMP_HIGH:   rd_mux = cmp[15:8];
            OFS_CCP_MODE:   rd_mux = ccp;
            OFS_PINS:       rd_mux = pin_view;
            default:        rd_mux = BYTE_RESET;
        endcase
    end

    // Registered outputs
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA          <= BYTE_RESET;
            IRQ            <= 1'b0;
            WAKE           <= 1'b0;
            COMPARE_EVENT  <= 1'b0;
            PIN5_DIRECTION <= 1'b1;
            PIN4_DIRECTION <= 1'b1;
            OSC_ENABLE     <= 1'b0;
        end else begin
            // Read data stand one cycle, zero otherwise
            RDATA          <= bus.rd ? rd_mux : BYTE_RESET;
            IRQ            <= flag && ien[0] && ien[1] && ien[2];
            WAKE           <= SLEEP && flag && ien[0] && ien[1] && ctrl.timer_on;
            COMPARE_EVENT  <= match;
            PIN5_DIRECTION <= dir5 || osc;
            PIN4_DIRECTION <= dir4 || osc;
            OSC_ENABLE     <= osc;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    // Last increment before the wrap, not overruled
    sequence s_wrap;
        pre_tick && count == COUNT_MAX && !wr_cnt && !special;
    endsequence

    // Low byte write and the cycle after it
    sequence s_low_write;
        wr_low ##1 1'b1;
    endsequence

    a_count_write: assert property (s_low_write |-> count[7:0] == $past(bus.wdata))
        else $error("low byte write not applied");
    a_prescale_clear: assert property (wr_cnt |=> pre == 3'h0)
        else $error("prescaler not cleared on count write");
    a_prescale_range: assert property (run && src_tick && !bus.wr |=> pre <= pre_last)
        else $error("prescaler past its last value");
    a_flag_set: assert property (s_wrap |=> flag && count == COUNT_RESET)
        else $error("rollover did not set flag");
    a_irq_gate: assert property (IRQ |-> $past(flag && ien == 3'h7))
        else $error("interrupt without all enables");
    a_special_clear: assert property (special && !wr_cnt |=> count == COUNT_RESET)
        else $error("special trigger did not clear count");
    a_write_wins: assert property (special && wr_high |=> count[15:8] == $past(bus.wdata))
        else $error("special trigger beat a write");
    a_disarm_write: assert property (wr_cnt |=> !armed)
        else $error("count write left input armed");
    a_osc_dirs: assert property (osc |=> PIN5_DIRECTION && PIN4_DIRECTION)
        else $error("oscillator pins not forced to input");
    a_gate_stop: assert property (ctrl.gate_enable && !gate_act |-> !pre_tick)
        else $error("counted while gate inactive");
    a_sleep_hold: assert property (SLEEP && !ctrl.sync_disable |-> !pre_tick)
        else $error("counted in sleep while synchronous");
    a_capture_copy: assert property (ccp.capture_enable && CAPTURE_EVENT |=>
                                     cmp == $past(count))
        else $error("capture did not copy count");
    // Checks on the bus, compare and event outputs
    a_high_write: assert property (wr_high |=> count[15:8] == $past(bus.wdata))
        else $error("high byte write not applied");
    a_compare_out: assert property (match |=> COMPARE_EVENT)
        else $error("compare match not signalled");
    a_osc_follow: assert property (osc |=> OSC_ENABLE)
        else $error("oscillator enable not driven");
    a_wake_terms: assert property (WAKE |-> $past(SLEEP && flag && ien[1:0] == 2'h3))
        else $error("wake without its enables");
    a_read_low: assert property (bus.rd && bus.addr == OFS_COUNT_LOW |=>
                                 RDATA == $past(count[7:0]))
        else $error("low byte read returned a stale value");
endmodule : gtm_timer
`default_nettype wire

// file: dv/gtm_partner.sv
// Far-side model: drives the external count input with pulse bursts
`timescale 1ns/1ns
`default_nettype none
module gtm_partner (
    // Clock
    input  wire logic       clk,
    // Burst request: pulse count and half period in cycles minus one
    input  wire logic       go,
    input  wire logic [7:0] n,
    input  wire logic [3:0] half,
    // Count line and burst status
    output var  logic       ext,
    output var  logic       busy
);
    logic [7:0] left; // Pulses still to send
    logic [3:0] cnt;  // Cycles left in this level
    initial begin
        ext  = 1'b0;
        busy = 1'b0;
        left = 8'h00;
        cnt  = 4'h0;
    end
    // Line idles low between bursts; each pulse is a rise then a fall
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            left <= n;
            cnt  <= half;
        end else if (busy) begin
            if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else begin
                cnt <= half;
                ext <= ~ext;
                if (ext) begin
                    left <= left - 8'h01;
                    busy <= (left != 8'h01);
                end
            end
        end
    end
endmodule : gtm_partner
`default_nettype wire

// file: dv/gated_sixteen_bit_timer_bench.sv
// Self-checking bench for the gated sixteen bit timer
`timescale 1ns/1ns
`default_nettype none
module gated_sixteen_bit_timer_bench;
    import gtm_pkg::*;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic       sys_clk = 1'b0, arst_n = 1'b0;  // Clock and reset
    logic [3:0] addr = 4'h0;                    // Register index
    logic [7:0] wdata = 8'h00, rdata;           // Bus data
    logic       wr_s = 1'b0, rd_s = 1'b0;       // Bus strobes
    logic       g_pin = 1'b0, g_alt = 1'b0, g_cmp = 1'b0; // Gate sources
    logic       cap = 1'b0, sleep = 1'b0;       // Capture strobe and sleep
    logic       irq, wake, cmp_ev, osc, dir5, dir4; // Event outputs
    logic       ext, p_go = 1'b0, p_busy;       // Partner link
    logic [7:0] p_n = 8'h00, b;                 // Burst length, read byte
    logic [3:0] p_half = 4'h4;                  // Burst half period
    logic [15:0] c;                             // Count read back
    int         error_cnt = 0, total_checks = 0;
    always #5 sys_clk = ~sys_clk;
    gtm_timer uut (.SYS_CLK(sys_clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .EXT_COUNT_IN(ext), .GATE_PIN_IN(g_pin),
        .ALT_GATE_PIN_IN(g_alt), .COMPARATOR_OUTPUT(g_cmp), .CAPTURE_EVENT(cap),
        .SLEEP(sleep), .PIN5_IN(1'b1), .PIN4_IN(1'b1), .PIN5_DIRECTION(dir5),
        .PIN4_DIRECTION(dir4), .OSC_ENABLE(osc), .IRQ(irq), .WAKE(wake),
        .COMPARE_EVENT(cmp_ev));
    gtm_partner model (.clk(sys_clk), .go(p_go), .n(p_n), .half(p_half), .ext(ext),
        .busy(p_busy));
    // ---------------------------------------------------------------
    // Bus and compare tasks
    // ---------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge sys_clk);
        wr_s  <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge sys_clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // Count is read low byte then high byte
    task automatic rd16(output logic [15:0] v);
        rd(OFS_COUNT_LOW, v[7:0]);
        rd(OFS_COUNT_HIGH, v[15:8]);
    endtask : rd16
    task automatic set_count(input logic [15:0] v);
        wr(OFS_COUNT_LOW, v[7:0]);
        wr(OFS_COUNT_HIGH, v[15:8]);
    endtask : set_count
    task automatic bad(input string m);
        error_cnt++;
        $display("BAD t=%0t %s", $time, m);
    endtask : bad
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) bad($sformatf("byte %h want %h", got, exp));
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) bad($sformatf("bit %b want %b", got, exp));
    endtask : chk_bit
    task automatic chk_near(input logic [15:0] got, input int exp, input int tol);
        total_checks++;
        if ($isunknown(got) || got < exp - tol || got > exp + tol) begin
            bad($sformatf("count %h want %0d", got, exp));
        end
    endtask : chk_near
    // Sends a burst through the partner and waits for it to end
    task automatic pulses(input logic [7:0] k, input logic [3:0] h);
        int i;
        @(posedge sys_clk);
        p_go   <= 1'b1;
        p_n    <= k;
        p_half <= h;
        @(posedge sys_clk);
        p_go <= 1'b0;
        #1;
        for (i = 0; i < 4000 && p_busy !== 1'b0; i++) @(posedge sys_clk);
        repeat (8) @(posedge sys_clk);
    endtask : pulses
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    logic [3:0] ofs [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'hF};
    logic [1:0] ps  [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
    initial begin
        int i, s, v;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // Reset values, unmapped index, pin view with oscillator off
        for (i = 0; i < 8; i++) begin
            rd(ofs[i], b);
            chk(b, 8'h00);
        end
        rd(OFS_PINS, b);
        chk(b, 8'h0F);
        set_count(16'h1234);
        rd16(c);
        chk_near(c, 16'h1234, 0);
        $display("registers done");
        // Source and prescale table: full clock 1..8, then instruction clock
        for (i = 0; i < 6; i++) begin
            v = (i < 4) ? (1 << i) : (4 << ps[i]);
            wr(OFS_SELECT, {7'h00, i < 4});
            set_count(16'h0000);
            wr(OFS_CONTROL, {2'b00, ps[i], 4'h1});
            repeat (64 * v - 1) @(posedge sys_clk);
            wr(OFS_CONTROL, 8'h00);
            rd16(c);
            chk_near(c, 64, 1);
        end
        $display("prescale done");
        // Rollover sets the flag; interrupt needs all three enables
        wr(OFS_SELECT, 8'h01);
        set_count(16'hFFF0);
        wr(OFS_CONTROL, 8'h01);
        repeat (40) @(posedge sys_clk);
        wr(OFS_CONTROL, 8'h00);
        rd(OFS_FLAGS, b);
        chk(b, 8'h01);
        for (i = 0; i < 8; i++) begin
            wr(OFS_ENABLES, i[7:0]);
            repeat (3) @(posedge sys_clk);
            chk_bit(irq, i == 7);
        end
        wr(OFS_FLAGS, 8'h00);
        repeat (3) @(posedge sys_clk);
        chk_bit(irq, 1'b0);
        $display("overflow done");
        // Compare match with special trigger acts as a period, no flag
        wr(OFS_CMP_LOW, 8'h10);
        wr(OFS_CMP_HIGH, 8'h00);
        wr(OFS_CCP_MODE, 8'h06);
        set_count(16'h0000);
        wr(OFS_CONTROL, 8'h01);
        for (i = 0; i < 100 && cmp_ev !== 1'b1; i++) @(posedge sys_clk);
        chk_bit(cmp_ev, 1'b1);
        repeat (300) @(posedge sys_clk);
        wr(OFS_CONTROL, 8'h00);
        rd16(c);
        chk_near(c, 8, 8);
        rd(OFS_FLAGS, b);
        chk(b, 8'h00);
        // Count write beats a special clear standing on a zero pair
        wr(OFS_CMP_LOW, 8'h00);
        wr(OFS_COUNT_LOW, 8'h00);
        wr(OFS_COUNT_HIGH, 8'hAB);
        rd16(c);
        chk_near(c, 16'hAB00, 0);
        // Capture copies the stopped count into the pair
        set_count(16'h5678);
        wr(OFS_CCP_MODE, 8'h01);
        @(posedge sys_clk);
        cap <= 1'b1;
        @(posedge sys_clk);
        cap <= 1'b0;
        rd(OFS_CMP_LOW, b);
        chk(b, 8'h78);
        rd(OFS_CMP_HIGH, b);
        chk(b, 8'h56);
        wr(OFS_CCP_MODE, 8'h00);
        $display("capture compare done");
        // Synchronous pin counting: first rise after a write is not counted
        set_count(16'h0000);
        wr(OFS_CONTROL, 8'h03);
        pulses(8'd5, 4'h4);
        wr(OFS_CONTROL, 8'h00);
        rd16(c);
        chk_near(c, 4, 0);
        // Asynchronous pin counting in sleep wakes on overflow
        sleep <= 1'b1;
        wr(OFS_ENABLES, 8'h03);
        wr(OFS_CONTROL, 8'h06);
        set_count(16'hFFFE);
        wr(OFS_CONTROL, 8'h07);
        pulses(8'd3, 4'h9);
        chk_bit(wake, 1'b1);
        wr(OFS_CONTROL, 8'h00);
        rd16(c);
        chk_near(c, 0, 0);
        wr(OFS_FLAGS, 8'h00);
        sleep <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk_bit(wake, 1'b0);
        $display("external done");
        // Gate: each source, each polarity; other sources stay inactive
        for (s = 0; s < 6; s++) begin
            g_pin <= ~s[0];
            g_alt <= ~s[0];
            g_cmp <= ~s[0];
            wr(OFS_SELECT, {5'h00, s[2:1], 1'b1});
            set_count(16'h0000);
            wr(OFS_CONTROL, {s[0], 7'h41});
            repeat (40) @(posedge sys_clk);
            if (s[2:1] == 2'h0) g_pin <= s[0];
            if (s[2:1] == 2'h1) g_alt <= s[0];
            if (s[2:1] == 2'h2) g_cmp <= s[0];
            repeat (40) @(posedge sys_clk);
            wr(OFS_CONTROL, 8'h00);
            rd16(c);
            chk_near(c, 40, 4);
        end
        $display("gate done");
        // Oscillator enable without timer run forces pins to inputs
        wr(OFS_PINS, 8'h00);
        rd(OFS_PINS, b);
        chk(b, 8'h03);
        chk_bit(dir5, 1'b0);
        wr(OFS_CONTROL, 8'h08);
        repeat (3) @(posedge sys_clk);
        chk_bit(osc, 1'b1);
        chk_bit(dir5, 1'b1);
        chk_bit(dir4, 1'b1);
        rd(OFS_PINS, b);
        chk(b, 8'h0C);
        wr(OFS_CONTROL, 8'h00);
        repeat (3) @(posedge sys_clk);
        chk_bit(osc, 1'b0);
        chk_bit(dir4, 1'b0);
        $display("oscillator done");
        give_verdict();
    end
    // Watchdog: the tests need well under half this span
    initial begin
        #500000;
        bad("watchdog expired");
        give_verdict();
    end
endmodule : gated_sixteen_bit_timer_bench
`default_nettype wire
